// File: verilog/sleep_mode_power_controller.sv
// Purpose: Sleep-state sequencer and power-domain controls
// Assumes: Core pulses sleep_instr; I/O bus is synchronous to sys_clk
// Notes:   Start-up length from clock source and start-up configuration
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_power_controller
    import sleep_pkg::*;
#(
    parameter int NPER = sleep_pkg::NUM_PERIPH
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Data-space register port
    input  wire logic [7:0]                data_addr,
    input  wire logic                      data_wr,
    input  wire logic                      data_rd,
    // I/O-space register port
    input  wire logic [5:0]                io_addr,
    input  wire logic                      io_wr,
    input  wire logic                      io_rd,
    // Shared write data and read data
    input  wire logic [7:0]                wdata,
    output logic [7:0]                     rdata,
    output logic                           rdata_valid,
    // Core interface
    input  wire logic                      sleep_instr,
    input  wire logic                      global_irq_en,
    output logic                           core_halt,
    output logic                           irq_service,
    // Configuration
    input  wire logic [3:0]                clock_source_config,
    input  wire logic [1:0]                startup_time_config,
    input  wire logic                      ext_crystal_sel,
    input  wire logic [NPER-1:0]           peripheral_clock_gate_bits,
    input  wire logic [1:0]                timer2_irq_mask,
    input  wire logic                      timer2_enabled,
    input  wire logic                      timer2_async,
    input  wire logic [2:0]                supply_monitor_level_fuses,
    input  wire logic                      debug_enable_fuse,
    input  wire logic                      boundary_port_enable_fuse,
    input  wire logic                      boundary_port_disable_bit,
    input  wire logic                      watchdog_enabled,
    input  wire logic                      adc_enabled,
    input  wire logic                      comparator_enabled,
    input  wire logic                      comparator_uses_ref,
    // Wake sources
    input  wire logic                      ext_reset_wake,
    input  wire logic                      watchdog_wake,
    input  wire logic                      supply_reset_wake,
    input  wire logic                      twi_addr_match,
    input  wire logic                      ext_level_irq,
    input  wire logic                      ext_edge_irq,
    input  wire logic                      pin_change_irq,
    input  wire logic                      timer2_ovf_irq,
    input  wire logic                      timer2_cmp_irq,
    input  wire logic                      adc_done_irq,
    input  wire logic                      nvm_ready_irq,
    input  wire logic                      other_io_irq,
    // Clock and power controls
    output logic                           clk_cpu_en,
    output logic                           clk_flash_en,
    output logic                           clk_io_en,
    output logic                           clk_adc_en,
    output logic                           clk_async_en,
    output logic                           main_osc_en,
    output logic                           timer2_osc_en,
    output logic                           watchdog_run,
    output logic                           supply_monitor_on,
    output logic                           comparator_on,
    output logic                           adc_on,
    output logic                           adc_extended_conv,
    output logic                           vref_on,
    output logic                           input_buf_en,
    output logic                           wake_pin_buf_en,
    output logic [NPER-1:0]                periph_clk_en,
    output logic [NPER-1:0]                periph_reg_access_en,
    output sleep_pkg::sleep_state_e        sleep_state
);
    logic [7:0]    ctrl_r;
    sleep_state_e  state_r;
    logic          waking_r;
    logic          halt_phase_r;
    logic          irq_pend_r;
    logic          adc_prev_r;
    logic          ext_conv_r;
    logic          ld;
    logic [CNT_W-1:0] ld_val;
    logic          cnt_done;
    logic          hit_data;
    logic          hit_io;
    logic          wake;
    logic          wake_irq;
    logic          t2_wake;
    logic          debug_on;
    logic [CNT_W-1:0] startup_cycles;

    // Decoded select to target state
    function automatic sleep_state_e sel_to_state(input logic [2:0] sel, input logic xtal);
        case (sel)
            SEL_IDLE:     sel_to_state = ST_IDLE;
            SEL_ADC_NR:   sel_to_state = ST_ADC_NR;
            SEL_PWR_DOWN: sel_to_state = ST_PWR_DOWN;
            SEL_PWR_SAVE: sel_to_state = ST_PWR_SAVE;
            SEL_STANDBY:  sel_to_state = xtal ? ST_STANDBY : ST_ACTIVE;
            SEL_EXT_STBY: sel_to_state = xtal ? ST_EXT_STBY : ST_ACTIVE;
            default:      sel_to_state = ST_ACTIVE;
        endcase
    endfunction : sel_to_state

    // Start-up delay from clock source and start-up configuration
    function automatic logic [CNT_W-1:0] startup_len(input logic [3:0] cks, input logic [1:0] stc);
        startup_len = CNT_W'(({12'h000, cks} + 16'h0001) << (4'(stc) + 4'h4));
    endfunction : startup_len

    assign startup_cycles = startup_len(clock_source_config, startup_time_config);

    // Address decode for both spaces
    assign hit_data = (data_addr == SLEEP_CTRL_DATA_OFS);
    assign hit_io   = (io_addr == 6'(SLEEP_CTRL_DATA_OFS - IO_SPACE_BASE));

    // Control register write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_r <= SLEEP_CTRL_RESET;
        end else if ((data_wr && hit_data) || (io_wr && hit_io)) begin
            ctrl_r <= {4'h0, wdata[SEL_MSB:ARM_BIT]};
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= (data_rd && hit_data) || (io_rd && hit_io);
            rdata       <= ((data_rd && hit_data) || (io_rd && hit_io)) ? ctrl_r : 8'h00;
        end
    end

    // Timer 2 wake qualified by mask and global enable
    assign t2_wake = global_irq_en && timer2_enabled &&
                     ((timer2_ovf_irq && timer2_irq_mask[0]) ||
                      (timer2_cmp_irq && timer2_irq_mask[1]));

    // Wake sources permitted per state
    always_comb begin
        wake_irq = 1'b0;
        case (state_r)
            ST_IDLE:     wake_irq = ext_level_irq || ext_edge_irq || pin_change_irq ||
                                    twi_addr_match || t2_wake || nvm_ready_irq ||
                                    adc_done_irq || watchdog_wake || other_io_irq;
            ST_ADC_NR:   wake_irq = ext_level_irq || pin_change_irq || twi_addr_match ||
                                    t2_wake || nvm_ready_irq || adc_done_irq || watchdog_wake;
            ST_PWR_DOWN,
            ST_STANDBY:  wake_irq = ext_level_irq || pin_change_irq || twi_addr_match ||
                                    watchdog_wake;
            ST_PWR_SAVE,
            ST_EXT_STBY: wake_irq = ext_level_irq || pin_change_irq || twi_addr_match ||
                                    watchdog_wake || t2_wake;
            default:     wake_irq = 1'b0;
        endcase
    end
    assign wake = wake_irq || ext_reset_wake || supply_reset_wake;

    // Wake delay load: start-up, six cycles, one cycle, or halt phase
    always_comb begin
        ld     = 1'b0;
        ld_val = '0;
        if (state_r != ST_ACTIVE && !waking_r && wake) begin
            ld = 1'b1;
            case (state_r)
                ST_PWR_DOWN,
                ST_PWR_SAVE: ld_val = startup_cycles;
                ST_STANDBY,
                ST_EXT_STBY: ld_val = CNT_W'(STANDBY_WAKE_CYCLES);
                default:     ld_val = CNT_W'(1);
            endcase
        end else if (waking_r && !halt_phase_r && cnt_done && irq_pend_r && wake_irq) begin
            ld     = 1'b1;
            ld_val = CNT_W'(IRQ_HALT_CYCLES);
        end
    end

    wake_counter #(
        .W        (CNT_W)
    ) u_wake_counter (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .load     (ld),
        .load_val (ld_val),
        .done     (cnt_done)
    );

    // Sleep state sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r      <= ST_ACTIVE;
            waking_r     <= 1'b0;
            halt_phase_r <= 1'b0;
            irq_pend_r   <= 1'b0;
        end else begin
            case (state_r)
                ST_ACTIVE: begin
                    if (sleep_instr && ctrl_r[ARM_BIT]) begin
                        state_r <= sel_to_state(ctrl_r[SEL_MSB:SEL_LSB], ext_crystal_sel);
                    end
                end
                default: begin
                    if (!waking_r) begin
                        if (wake) begin
                            waking_r   <= 1'b1;
                            irq_pend_r <= wake_irq && !ext_reset_wake && !supply_reset_wake;
                        end
                    end else if (!halt_phase_r && cnt_done) begin
                        // Halt only while a permitted source still asserts
                        if (irq_pend_r && wake_irq) begin
                            halt_phase_r <= 1'b1;
                        end else begin
                            irq_pend_r <= 1'b0;
                            waking_r   <= 1'b0;
                            state_r    <= ST_ACTIVE;
                        end
                    end else if (halt_phase_r && !ld && cnt_done) begin
                        halt_phase_r <= 1'b0;
                        waking_r     <= 1'b0;
                        state_r      <= ST_ACTIVE;
                    end
                end
            endcase
        end
    end

    // One-cycle interrupt service pulse on resume
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_service <= 1'b0;
        end else begin
            irq_service <= halt_phase_r && !ld && cnt_done;
        end
    end

    assign core_halt   = (state_r != ST_ACTIVE);
    assign sleep_state = state_r;
    assign debug_on    = debug_enable_fuse && boundary_port_enable_fuse &&
                         !boundary_port_disable_bit;

    // Clock domain and oscillator enables per state
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clk_cpu_en    <= 1'b1;
            clk_flash_en  <= 1'b1;
            clk_io_en     <= 1'b1;
            clk_adc_en    <= 1'b1;
            clk_async_en  <= 1'b1;
            main_osc_en   <= 1'b1;
            timer2_osc_en <= 1'b1;
        end else begin
            clk_cpu_en    <= (state_r == ST_ACTIVE);
            clk_flash_en  <= (state_r == ST_ACTIVE);
            clk_io_en     <= (state_r == ST_ACTIVE) || (state_r == ST_IDLE);
            clk_adc_en    <= (state_r == ST_ACTIVE) || (state_r == ST_IDLE) ||
                             (state_r == ST_ADC_NR);
            clk_async_en  <= (state_r inside {ST_ACTIVE, ST_IDLE, ST_ADC_NR}) ||
                             ((state_r inside {ST_PWR_SAVE, ST_EXT_STBY}) && timer2_async);
            main_osc_en   <= (state_r inside {ST_ACTIVE, ST_IDLE, ST_ADC_NR,
                                              ST_STANDBY, ST_EXT_STBY}) ||
                             ((state_r == ST_PWR_SAVE) && !timer2_async) ||
                             debug_on;
            timer2_osc_en <= (state_r inside {ST_ACTIVE, ST_IDLE, ST_ADC_NR}) ? timer2_async
                             : ((state_r inside {ST_PWR_SAVE, ST_EXT_STBY}) && timer2_async);
        end
    end

    // Analog blocks, monitor, watchdog and buffers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            watchdog_run      <= 1'b0;
            supply_monitor_on <= 1'b0;
            comparator_on     <= 1'b0;
            adc_on            <= 1'b0;
            vref_on           <= 1'b0;
            input_buf_en      <= 1'b1;
            wake_pin_buf_en   <= 1'b1;
        end else begin
            watchdog_run      <= watchdog_enabled;
            supply_monitor_on <= (supply_monitor_level_fuses != 3'h7);
            adc_on            <= adc_enabled;
            comparator_on     <= comparator_enabled &&
                                 ((state_r inside {ST_ACTIVE, ST_IDLE, ST_ADC_NR}) ||
                                  comparator_uses_ref);
            vref_on           <= (supply_monitor_level_fuses != 3'h7) || adc_enabled ||
                                 (comparator_enabled && comparator_uses_ref);
            input_buf_en      <= (state_r inside {ST_ACTIVE, ST_IDLE, ST_ADC_NR});
            wake_pin_buf_en   <= 1'b1;
        end
    end

    // Extended conversion after ADC off-on cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            adc_prev_r <= 1'b0;
            ext_conv_r <= 1'b1;
        end else begin
            adc_prev_r <= adc_enabled;
            if (adc_enabled && !adc_prev_r) begin
                ext_conv_r <= 1'b1;
            end else if (adc_done_irq) begin
                ext_conv_r <= 1'b0;
            end
        end
    end
    assign adc_extended_conv = ext_conv_r;

    periph_clock_gate #(
        .N                    (NPER)
    ) u_periph_clock_gate (
        .sys_clk              (sys_clk),
        .reset                (reset),
        .gate_bits            (peripheral_clock_gate_bits),
        .io_clock_on          ((state_r == ST_ACTIVE) || (state_r == ST_IDLE)),
        .periph_clk_en        (periph_clk_en),
        .periph_reg_access_en (periph_reg_access_en)
    );
endmodule : sleep_mode_power_controller
`default_nettype wire

// File: verilog/sleep_pkg.sv
// Purpose: Shared constants and types for the sleep-mode power controller
// Assumes: Single system clock, synchronous active-high reset
// Notes:   Offsets, field positions, reset values and cycle counts live here
package sleep_pkg;
    // Register addressing
    localparam logic [7:0] SLEEP_CTRL_DATA_OFS = 8'h53;
    localparam logic [7:0] IO_SPACE_BASE       = 8'h20;
    localparam logic [5:0] SLEEP_CTRL_IO_OFS   = 6'h33;
    localparam logic [7:0] SLEEP_CTRL_RESET    = 8'h00;
    localparam int         ARM_BIT             = 0;
    localparam int         SEL_LSB             = 1;
    localparam int         SEL_MSB             = 3;
    // Mode select encodings
    localparam logic [2:0] SEL_IDLE     = 3'h0;
    localparam logic [2:0] SEL_ADC_NR   = 3'h1;
    localparam logic [2:0] SEL_PWR_DOWN = 3'h2;
    localparam logic [2:0] SEL_PWR_SAVE = 3'h3;
    localparam logic [2:0] SEL_STANDBY  = 3'h6;
    localparam logic [2:0] SEL_EXT_STBY = 3'h7;
    // Wake timing in cycles
    localparam int         STANDBY_WAKE_CYCLES = 6;
    localparam int         IRQ_HALT_CYCLES     = 4;
    localparam int         CNT_W               = 16;
    // Peripheral gate count
    localparam int         NUM_PERIPH = 8;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_IDLE,
        ST_ADC_NR,
        ST_PWR_DOWN,
        ST_PWR_SAVE,
        ST_STANDBY,
        ST_EXT_STBY
    } sleep_state_e;
endpackage : sleep_pkg

// File: verilog/wake_counter.sv
// Purpose: Down-counter timing wake start-up and halt intervals
// Assumes: Load has priority over counting
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module wake_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // Status
    output logic              done
);
    logic [W-1:0] count_r;

    // Load or count down to zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_val;
        end else if (count_r != '0) begin
            count_r <= count_r - W'(1);
        end
    end

    assign done = (count_r == '0);
endmodule : wake_counter
`default_nettype wire

// File: verilog/periph_clock_gate.sv
// Purpose: Per-peripheral clock enable gating
// Assumes: Gated peripherals hold state while enable is low
// Notes:   Enable drives a clock-gate cell in the peripheral
`timescale 1ns/1ps
`default_nettype none
module periph_clock_gate #(
    parameter int N = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // Control
    input  wire logic [N-1:0] gate_bits,
    input  wire logic         io_clock_on,
    // Outputs
    output logic [N-1:0]      periph_clk_en,
    output logic [N-1:0]      periph_reg_access_en
);
    // Registered enables, one per peripheral
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            periph_clk_en        <= '0;
            periph_reg_access_en <= '0;
        end else begin
            periph_clk_en        <= ~gate_bits & {N{io_clock_on}};
            periph_reg_access_en <= ~gate_bits;
        end
    end
endmodule : periph_clock_gate
`default_nettype wire

// File: sim/sleep_checker.sv
// Purpose: Port-level assertions for the sleep controller
// Assumes: Control outputs lag their cause by one cycle
// Notes:   Bound into every controller instance
`timescale 1ns/1ps
`default_nettype none
module sleep_checker
    import sleep_pkg::*;
#(
    parameter int NPER = 8
) (
    // Watched ports
    input wire logic sys_clk, reset, io_rd, data_rd, rdata_valid, irq_service, core_halt,
    input wire logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_async_en, main_osc_en,
    input wire logic debug_enable_fuse, boundary_port_enable_fuse, boundary_port_disable_bit,
    input wire logic watchdog_enabled, watchdog_run, adc_enabled, adc_on, supply_monitor_on,
    input wire logic comparator_uses_ref, comparator_on,
    input wire logic [2:0] supply_monitor_level_fuses,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] data_addr, rdata,
    input wire logic [NPER-1:0] peripheral_clock_gate_bits, periph_clk_en, periph_reg_access_en,
    input wire sleep_state_e sleep_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_read_hit: assert property ((io_rd && io_addr == SLEEP_CTRL_IO_OFS)
        || (data_rd && data_addr == SLEEP_CTRL_DATA_OFS) |=> rdata_valid) else $error("hit no valid");
    a_read_miss: assert property ((!io_rd || io_addr != SLEEP_CTRL_IO_OFS) && (!data_rd ||
        data_addr != SLEEP_CTRL_DATA_OFS) |=> !rdata_valid && rdata == 8'h00) else $error("miss");
    a_upper_zero: assert property (rdata[7:4] == 4'h0) else $error("upper bits set");
    a_deep_clocks: assert property ((sleep_state == ST_PWR_DOWN && !debug_enable_fuse)[*2]
        |-> !clk_cpu_en && !clk_io_en && !clk_adc_en && !clk_async_en && !main_osc_en)
        else $error("clock left on in power-down");
    a_idle_clocks: assert property ((sleep_state == ST_IDLE)[*2] |-> !clk_cpu_en
        && !clk_flash_en && clk_io_en && clk_adc_en) else $error("idle clock set wrong");
    a_standby_osc: assert property ((sleep_state == ST_STANDBY)[*2] |-> main_osc_en
        && !clk_io_en) else $error("standby oscillator wrong");
    a_debug_clock: assert property ((debug_enable_fuse && boundary_port_enable_fuse
        && !boundary_port_disable_bit)[*2] |-> main_osc_en) else $error("debug lost clock");
    a_gate_follow: assert property ((sleep_state == ST_ACTIVE && $stable(peripheral_clock_gate_bits))[*3]
        |-> periph_clk_en == ~peripheral_clock_gate_bits
        && periph_reg_access_en == ~peripheral_clock_gate_bits) else $error("gate mismatch");
    a_deep_gated: assert property ((sleep_state == ST_PWR_DOWN)[*3] |-> periph_clk_en == '0)
        else $error("peripheral clock in power-down");
    a_keep_on: assert property ((supply_monitor_level_fuses != 3'h7 && watchdog_enabled
        && adc_enabled)[*2] |-> supply_monitor_on && watchdog_run && adc_on) else $error("unit off");
    a_comp_off: assert property ((sleep_state == ST_PWR_DOWN && !comparator_uses_ref)[*2]
        |-> !comparator_on) else $error("comparator on");
    a_irq_halt: assert property (irq_service |-> !core_halt && $past(core_halt)
        && $past(core_halt, 4)) else $error("short halt");
endmodule : sleep_checker
bind sleep_mode_power_controller sleep_checker #(.NPER(NPER)) u_chk (.*);
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the sleep controller
// Assumes: Fixed seed, stimulus at rising edges
// Notes:   Wake latency checked against start-up window
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import sleep_pkg::*;
    logic sys_clk, reset, data_wr, data_rd, io_wr, io_rd, sleep_instr, global_irq_en, ext_crystal_sel;
    logic timer2_enabled, timer2_async, debug_enable_fuse, boundary_port_enable_fuse, irq_seen;
    logic boundary_port_disable_bit, watchdog_enabled, adc_enabled, comparator_enabled;
    logic comparator_uses_ref, ext_reset_wake, watchdog_wake, supply_reset_wake, twi_addr_match;
    logic ext_level_irq, ext_edge_irq, pin_change_irq, timer2_ovf_irq, timer2_cmp_irq, adc_done_irq;
    logic nvm_ready_irq, other_io_irq, rdata_valid, core_halt, irq_service, clk_cpu_en, clk_flash_en;
    logic clk_io_en, clk_adc_en, clk_async_en, main_osc_en, timer2_osc_en, watchdog_run, adc_on;
    logic supply_monitor_on, comparator_on, adc_extended_conv, vref_on, input_buf_en, wake_pin_buf_en;
    logic [7:0] data_addr, wdata, rdata, peripheral_clock_gate_bits, periph_clk_en, periph_reg_access_en;
    logic [5:0] io_addr;
    logic [3:0] clock_source_config;
    logic [1:0] startup_time_config, timer2_irq_mask;
    logic [2:0] supply_monitor_level_fuses;
    sleep_state_e sleep_state, e;
    int seed = 32'h2A9FBB33;
    int n_fail = 0;
    int tests_run = 0;
    int n, d;
    logic [31:0] r;
    sleep_mode_power_controller u_sleep_mode_power_controller (.*);
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Interrupt service pulse catcher
    always @(posedge sys_clk) if (irq_service === 1'b1) irq_seen <= 1'b1;
    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // One register access, read data sampled after the answer edge
    task automatic acc(input logic io, input logic rd, input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        {io_addr, data_addr, wdata} <= {a[5:0], a, v};
        {io_wr, io_rd, data_wr, data_rd} <= {io & !rd, io & rd, !io & !rd, !io & rd};
        @(posedge sys_clk);
        {io_wr, io_rd, data_wr, data_rd} <= 4'h0;
        @(negedge sys_clk);
    endtask : acc
    task automatic nap(input logic [2:0] s, input logic arm);
        acc(1'b1, 1'b0, 8'h33, {4'h0, s, arm});
        @(posedge sys_clk) sleep_instr <= 1'b1;
        @(posedge sys_clk) sleep_instr <= 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : nap
    task automatic wait_state(input sleep_state_e s);
        for (n = 0; sleep_state !== s; n++) begin
            @(negedge sys_clk);
            if (n > 3000) begin n_fail++; final_report(); end
        end
    endtask : wait_state
    function automatic sleep_state_e exp_state(input logic [3:0] k, input logic x);
        case (k)
            4'h1: return ST_IDLE;
            4'h3: return ST_ADC_NR;
            4'h5: return ST_PWR_DOWN;
            4'h7: return ST_PWR_SAVE;
            4'hD: return x ? ST_STANDBY : ST_ACTIVE;
            4'hF: return x ? ST_EXT_STBY : ST_ACTIVE;
            default: return ST_ACTIVE;
        endcase
    endfunction : exp_state
    initial begin
        {data_wr, data_rd, io_wr, io_rd, sleep_instr, timer2_async, debug_enable_fuse, irq_seen} = '0;
        {boundary_port_enable_fuse, boundary_port_disable_bit, comparator_uses_ref, other_io_irq} = '0;
        {ext_reset_wake, watchdog_wake, supply_reset_wake, twi_addr_match, ext_level_irq} = '0;
        {ext_edge_irq, pin_change_irq, timer2_ovf_irq, timer2_cmp_irq, adc_done_irq, nvm_ready_irq} = '0;
        {global_irq_en, ext_crystal_sel, timer2_enabled, watchdog_enabled, adc_enabled} = '1;
        {comparator_enabled, supply_monitor_level_fuses} = 4'hC;
        {data_addr, io_addr, wdata, clock_source_config, startup_time_config} = '0;
        {timer2_irq_mask, peripheral_clock_gate_bits} = '0;
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        // Register map: both spaces, misses, reset value
        acc(1'b1, 1'b1, 8'h33, 8'h00);
        `CHK({rdata_valid, rdata}, 9'h100)
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            acc(i[0], 1'b0, i[0] ? 8'h33 : 8'h53, r[7:0]);
            acc(1'b0, 1'b0, 8'h33, ~r[7:0]);
            acc(!i[0], 1'b1, i[0] ? 8'h53 : 8'h33, 8'h00);
            `CHK({rdata_valid, rdata}, {5'h10, r[3:0]})
            acc(1'b1, 1'b1, 8'h13, 8'h00);
            `CHK({rdata_valid, rdata}, 9'h000)
        end
        $display("register map test done");
        // Every select code, with and without crystal or arm bit
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            {clock_source_config, startup_time_config, peripheral_clock_gate_bits} <= r[13:0];
            {debug_enable_fuse, boundary_port_enable_fuse, timer2_async} <= r[16:14];
            ext_crystal_sel <= i < 8 || r[17];
            nap(i[2:0], i < 8 || r[18]);
            e = exp_state({i[2:0], i < 8 || r[18]}, i < 8 || r[17]);
            `CHK(sleep_state, e)
            `CHK(input_buf_en, e inside {ST_ACTIVE, ST_IDLE, ST_ADC_NR})
            `CHK(timer2_osc_en, r[14] && !(e inside {ST_PWR_DOWN, ST_STANDBY}))
            d = i[2:1] == 2'h1 ? (r[13:10] + 1) << (r[9:8] + 4) : i[2:1] == 2'h3 ? 6 : 1;
            if (e != ST_ACTIVE) begin
                irq_seen = 1'b0;
                @(posedge sys_clk) pin_change_irq <= 1'b1;
                wait_state(ST_ACTIVE);
                pin_change_irq <= 1'b0;
                `CHK({irq_seen | irq_service, n >= d && n <= d + 10}, 2'h3)
            end
            repeat (4) @(negedge sys_clk);
            `CHK(periph_clk_en, ~peripheral_clock_gate_bits)
        end
        $display("sleep select test done");
        // Pin-change request that vanishes before start-up ends
        {clock_source_config, startup_time_config} <= 6'h0;
        nap(SEL_PWR_DOWN, 1'b1);
        irq_seen = 1'b0;
        @(posedge sys_clk) pin_change_irq <= 1'b1;
        @(posedge sys_clk) pin_change_irq <= 1'b0;
        wait_state(ST_ACTIVE);
        `CHK(irq_seen | irq_service, 1'b0)
        // Wake sources that must not wake, then timer 2 masking
        {ext_edge_irq, other_io_irq, timer2_ovf_irq, timer2_irq_mask} <= 5'h1C;
        nap(SEL_PWR_DOWN, 1'b1);
        for (int k = 0; k < 4; k++) begin
            repeat (40) @(negedge sys_clk);
            `CHK(sleep_state, k < 2 ? ST_PWR_DOWN : ST_PWR_SAVE)
            @(posedge sys_clk) {timer2_irq_mask, global_irq_en} <= {k == 1 ? 2'h0 : 2'h1, k != 2};
            if (k == 1) begin
                twi_addr_match <= 1'b1;
                wait_state(ST_ACTIVE);
                twi_addr_match <= 1'b0;
                nap(SEL_PWR_SAVE, 1'b1);
            end
        end
        wait_state(ST_ACTIVE);
        `CHK({irq_service, n >= 16 && n <= 26}, 2'h3)
        $display("wake source test done");
        // Converter cycled off and on asks for an extended conversion
        @(posedge sys_clk) adc_done_irq <= 1'b1;
        @(posedge sys_clk) {adc_enabled, adc_done_irq} <= 2'h0;
        @(negedge sys_clk) `CHK(adc_extended_conv, 1'b0)
        @(posedge sys_clk) adc_enabled <= 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK({adc_extended_conv, adc_on}, 2'h3)
        $display("conversion test done");
        final_report();
    end
endmodule : tb
`default_nettype wire
